/* File: src/isf_pkg.sv */
// constants, offsets and field layout of the i2c status flag logic
package isf_pkg;
    // -----------------------------------------------------------------
    // register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] ISF_OFF_STATUS = 8'h00;
    localparam logic [7:0] ISF_OFF_CTRL_ONE = 8'h04;
    localparam logic [7:0] ISF_OFF_CTRL_TWO = 8'h08;
    localparam logic [7:0] ISF_OFF_PRIMARY = 8'h0C;
    localparam logic [7:0] ISF_OFF_RANGE = 8'h10;
    localparam logic [7:0] ISF_OFF_SECOND = 8'h14;
    localparam logic [7:0] ISF_OFF_FILTER = 8'h18;
    localparam logic [7:0] ISF_OFF_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] ISF_OFF_IRQ_MASK = 8'h20;
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int ISF_ST_RANGE_MATCH = 3;
    localparam int ISF_ST_SLAVE_DIR = 2;
    localparam int ISF_ST_IRQ_PEND = 1;
    localparam int ISF_C1_TX_ACK = 3;
    localparam int ISF_C2_GCALL_EN = 7;
    localparam int ISF_C2_RANGE_EN = 3;
    localparam int ISF_C2_FAST_ACK = 2;
    localparam int ISF_C2_ALERT_EN = 1;
    localparam int ISF_C2_SECOND_EN = 0;
    localparam int ISF_FLT_STOP_DET = 6;
    localparam int ISF_FLT_SS_IRQ_EN = 5;
    localparam int ISF_FLT_START_DET = 4;
    // -----------------------------------------------------------------
    // event bits of the interrupt status and mask registers
    // -----------------------------------------------------------------
    localparam int ISF_EV_BYTE = 0;
    localparam int ISF_EV_ADDR = 1;
    localparam int ISF_EV_ARB = 2;
    localparam int ISF_EV_TIMEOUT = 3;
    localparam int ISF_EV_STOP = 4;
    localparam int ISF_EV_START = 5;
    localparam int ISF_EV_W = 6;
    // -----------------------------------------------------------------
    // timeout inputs and fixed addresses
    // -----------------------------------------------------------------
    localparam int ISF_TO_SCL_LOW = 0;
    localparam int ISF_TO_SCL_HIGH = 1;
    localparam int ISF_TO_SDA_HIGH = 2;
    localparam logic [6:0] ISF_GCALL_ADDR = 7'h00;
    localparam logic [6:0] ISF_ALERT_ADDR = 7'h0C;
    localparam logic [3:0] ISF_BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] ISF_RESET_BYTE = 8'h00;
    localparam logic [1:0] ISF_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] ISF_HRESP_OKAY = 2'h0;
    typedef enum logic [1:0] {ISF_IDLE, ISF_ADDR, ISF_DATA, ISF_SKIP} isf_state_e;
endpackage : isf_pkg

/* File: src/isf_status_flags.sv */
// i2c slave address match, direction and interrupt pending flags with ahb-lite registers
//
// Contract
// - with range matching on, a nonzero calling address equal to the range address sets the range match flag.
// - with range matching on, a calling address between primary and range address sets the range match flag.
// - any write to control register one clears the range match flag.
// - status bit 2 shows the read/write bit of the calling address that addressed this slave.
// - status bit 1 is set whenever an interrupt is pending and software clears it by writing one.
// - with fast ack off, the pending flag sets when a byte and its acknowledge bit have finished.
// - in receive mode the acknowledge bit driven is ack for transmit ack value 0 and nack for 1.
// - with fast ack on, the pending flag sets right after the eighth data bit, before acknowledge.
// - an address match of any kind, or lost arbitration, sets the pending flag.
// - every smbus timeout sets the pending flag except the clock high and data high timeouts.
// - with the stop/start interrupt enable set, a detected stop or start sets the pending flag.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module isf_status_flags (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // i2c pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // events from the surrounding controller
    input wire logic arb_lost_pulse,
    input wire logic smbus_mode,
    input wire logic [2:0] timeout_pulse,
    // interrupt
    output logic irq
);
    import isf_pkg::*;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                       input logic clr_en, input logic [7:0] wdata);
        // a set in the clearing cycle wins
        w1c = set | (cur & ~(clr_en ? wdata : ISF_RESET_BYTE));
    endfunction : w1c

    function automatic logic in_span(input logic [6:0] a, input logic [6:0] b,
                                     input logic [6:0] c);
        in_span = (a <= b) ? ((c >= a) && (c <= b)) : ((c >= b) && (c <= a));
    endfunction : in_span

    // -----------------------------------------------------------------
    // ahb-lite slave
    // -----------------------------------------------------------------
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [1:0] hresp_q;
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;
    logic [6:0] primary_q;
    logic [6:0] range_q;
    logic [6:0] second_q;
    logic [7:0] filter_q;
    logic [7:0] filter_d;
    logic [7:0] irq_status_q;
    logic [7:0] irq_status_d;
    logic [7:0] irq_mask_q;
    logic range_match_q;
    logic slave_dir_q;
    logic irq_pend_q;
    logic irq_q;

    wire logic ap_take = hsel && hready && (htrans == ISF_HTRANS_NONSEQ);
    wire logic [7:0] wb = hwdata[7:0];
    wire logic wr_status = dp_wr_q && (dp_addr_q == ISF_OFF_STATUS);
    wire logic wr_ctrl_one = dp_wr_q && (dp_addr_q == ISF_OFF_CTRL_ONE);
    wire logic wr_ctrl_two = dp_wr_q && (dp_addr_q == ISF_OFF_CTRL_TWO);
    wire logic wr_primary = dp_wr_q && (dp_addr_q == ISF_OFF_PRIMARY);
    wire logic wr_range = dp_wr_q && (dp_addr_q == ISF_OFF_RANGE);
    wire logic wr_second = dp_wr_q && (dp_addr_q == ISF_OFF_SECOND);
    wire logic wr_filter = dp_wr_q && (dp_addr_q == ISF_OFF_FILTER);
    wire logic wr_irq_status = dp_wr_q && (dp_addr_q == ISF_OFF_IRQ_STATUS);
    wire logic wr_irq_mask = dp_wr_q && (dp_addr_q == ISF_OFF_IRQ_MASK);

    wire logic [7:0] status_byte = {4'h0, range_match_q, slave_dir_q, irq_pend_q, 1'b0};
    logic [7:0] rd_byte;
    always_comb begin
        unique case (haddr[7:0])
            ISF_OFF_STATUS: rd_byte = status_byte;
            ISF_OFF_CTRL_ONE: rd_byte = ctrl_one_q;
            ISF_OFF_CTRL_TWO: rd_byte = ctrl_two_q;
            ISF_OFF_PRIMARY: rd_byte = {primary_q, 1'b0};
            ISF_OFF_RANGE: rd_byte = {range_q, 1'b0};
            ISF_OFF_SECOND: rd_byte = {second_q, 1'b0};
            ISF_OFF_FILTER: rd_byte = filter_q;
            ISF_OFF_IRQ_STATUS: rd_byte = irq_status_q;
            ISF_OFF_IRQ_MASK: rd_byte = irq_mask_q;
            default: rd_byte = ISF_RESET_BYTE;
        endcase
    end

    // read data is fetched in the address phase, so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= ISF_RESET_BYTE;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= ISF_HRESP_OKAY;
        end else begin
            dp_wr_q <= ap_take && hwrite;
            dp_addr_q <= haddr[7:0];
            hrdata_q <= (ap_take && !hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= ISF_HRESP_OKAY;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_one_q <= ISF_RESET_BYTE;
            ctrl_two_q <= ISF_RESET_BYTE;
            primary_q <= 7'h00;
            range_q <= 7'h00;
            second_q <= 7'h00;
            irq_mask_q <= ISF_RESET_BYTE;
        end else begin
            if (wr_ctrl_one) ctrl_one_q <= wb;
            if (wr_ctrl_two) ctrl_two_q <= wb;
            if (wr_primary) primary_q <= wb[7:1];
            if (wr_range) range_q <= wb[7:1];
            if (wr_second) second_q <= wb[7:1];
            if (wr_irq_mask) irq_mask_q <= {2'b00, wb[ISF_EV_W-1:0]};
        end
    end

    wire logic range_en = ctrl_two_q[ISF_C2_RANGE_EN];
    wire logic fast_ack = ctrl_two_q[ISF_C2_FAST_ACK];
    wire logic tx_ack_val = ctrl_one_q[ISF_C1_TX_ACK];
    wire logic ss_irq_en = filter_q[ISF_FLT_SS_IRQ_EN];

    // -----------------------------------------------------------------
    // pin synchronisers and bus condition detection
    // -----------------------------------------------------------------
    logic scl_m_q;
    logic scl_s_q;
    logic scl_p_q;
    logic sda_m_q;
    logic sda_s_q;
    logic sda_p_q;
    // both pins pass the same number of flops, so start and stop are seen in order
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end else begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
        end
    end
    wire logic scl_rise = scl_s_q && !scl_p_q;
    wire logic scl_fall = !scl_s_q && scl_p_q;
    wire logic start_det = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
    wire logic stop_det = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;

    // -----------------------------------------------------------------
    // slave byte engine
    // -----------------------------------------------------------------
    isf_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic ack_phase_q;
    logic hit_q;
    logic sda_oe_q;

    wire logic [7:0] byte_in = {shift_q[6:0], sda_s_q};
    wire logic [6:0] call_addr = byte_in[7:1];
    wire logic last_bit = scl_rise && (bit_cnt_q == ISF_BITS_PER_BYTE - 4'h1);
    // the span holds either way round and includes both end points
    wire logic range_hit = range_en && (((call_addr != 7'h00) && (call_addr == range_q))
        || in_span(primary_q, range_q, call_addr));
    wire logic any_hit = (call_addr == primary_q) || range_hit
        || (ctrl_two_q[ISF_C2_GCALL_EN] && (call_addr == ISF_GCALL_ADDR))
        || (ctrl_two_q[ISF_C2_ALERT_EN] && (call_addr == ISF_ALERT_ADDR))
        || (ctrl_two_q[ISF_C2_SECOND_EN] && (call_addr == second_q));
    wire logic addr_event = (state_q == ISF_ADDR) && last_bit && any_hit;
    wire logic data_bits_done = (state_q == ISF_DATA) && last_bit;
    wire logic ack_end = ack_phase_q && scl_fall;
    wire logic data_ack_done = (state_q == ISF_DATA) && ack_end;
    wire logic byte_event = fast_ack ? data_bits_done : data_ack_done;
    // a receiving slave acknowledges unless software asked for nack
    wire logic drive_ack = (state_q == ISF_ADDR) ? hit_q : (!slave_dir_q && !tx_ack_val);
    // a start or stop aborts whatever byte is in flight

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ISF_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= ISF_RESET_BYTE;
            ack_phase_q <= 1'b0;
            hit_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_det || stop_det) begin
            state_q <= start_det ? ISF_ADDR : ISF_IDLE;
            bit_cnt_q <= 4'h0;
            ack_phase_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (state_q != ISF_IDLE && state_q != ISF_SKIP) begin
            if (scl_rise && !ack_phase_q && bit_cnt_q != ISF_BITS_PER_BYTE) begin
                shift_q <= byte_in;
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (state_q == ISF_ADDR) hit_q <= any_hit;
            end
            if (scl_fall && bit_cnt_q == ISF_BITS_PER_BYTE && !ack_phase_q) begin
                ack_phase_q <= 1'b1;
                sda_oe_q <= drive_ack;
            end else if (ack_end) begin
                ack_phase_q <= 1'b0;
                sda_oe_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                state_q <= (state_q == ISF_DATA || hit_q) ? ISF_DATA : ISF_SKIP;
            end
        end
    end

    // -----------------------------------------------------------------
    // status flags
    // -----------------------------------------------------------------
    // the clock-high and data-high timeouts never raise the pending flag
    wire logic timeout_event = smbus_mode && timeout_pulse[ISF_TO_SCL_LOW];
    logic [7:0] flt_set;
    logic [7:0] ev_set;
    always_comb begin
        flt_set = ISF_RESET_BYTE;
        flt_set[ISF_FLT_STOP_DET] = stop_det;
        flt_set[ISF_FLT_START_DET] = start_det;
        ev_set = ISF_RESET_BYTE;
        ev_set[ISF_EV_BYTE] = byte_event;
        ev_set[ISF_EV_ADDR] = addr_event;
        ev_set[ISF_EV_ARB] = arb_lost_pulse;
        ev_set[ISF_EV_TIMEOUT] = timeout_event;
        ev_set[ISF_EV_STOP] = stop_det;
        ev_set[ISF_EV_START] = start_det;
    end
    wire logic [7:0] flt_kept = w1c(filter_q, flt_set, wr_filter, wb);
    // only the two detect flags and the enable are kept, the rest reads zero
    assign filter_d = {1'b0, flt_kept[ISF_FLT_STOP_DET],
                       wr_filter ? wb[ISF_FLT_SS_IRQ_EN] : ss_irq_en,
                       flt_kept[ISF_FLT_START_DET], 4'h0};
    assign irq_status_d = w1c(irq_status_q, ev_set, wr_irq_status, wb);

    // a still-set stop/start flag keeps requesting, so clearing pending first does not stick
    wire logic ss_pending = ss_irq_en
        && (filter_q[ISF_FLT_STOP_DET] || filter_q[ISF_FLT_START_DET]);
    wire logic pend_set = byte_event
        || addr_event || arb_lost_pulse
        || timeout_event || ss_pending;
    wire logic pend_clr = wr_status && wb[ISF_ST_IRQ_PEND];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filter_q <= ISF_RESET_BYTE;
            irq_status_q <= ISF_RESET_BYTE;
            range_match_q <= 1'b0;
            slave_dir_q <= 1'b0;
            irq_pend_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            filter_q <= filter_d;
            irq_status_q <= irq_status_d;
            range_match_q <= (addr_event && range_hit) || (range_match_q && !wr_ctrl_one);
            if (addr_event) slave_dir_q <= byte_in[0];
            irq_pend_q <= pend_set || (irq_pend_q && !pend_clr);
            irq_q <= |(irq_status_d & irq_mask_q);
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    // open drain: the pin is only ever pulled low, never driven high
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;
    assign irq = irq_q;

    wire logic unused_ok = &{1'b0, haddr[31:8], hsize, hwdata[31:8], timeout_pulse[2:1],
                             scl_s_q & 1'b0};
endmodule : isf_status_flags
`default_nettype wire

/* File: verification/isf_checker.sv */
// concurrent checks on the ports of the status flag block
`timescale 1ns/1ns
`default_nettype none
module isf_checker (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    // pins and interrupt
    input wire logic scl_i,
    input wire logic sda_oe,
    input wire logic irq
);
    import isf_pkg::*;
    // -----------------------------------------------------------------
    // data phase trackers
    // -----------------------------------------------------------------
    wire logic take = hsel && hready && (htrans == ISF_HTRANS_NONSEQ);
    logic rd_q;
    logic wr_q;
    logic st_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            st_q <= 1'b0;
        end else begin
            rd_q <= take && !hwrite;
            wr_q <= take && hwrite;
            st_q <= take && !hwrite && (haddr[7:0] == ISF_OFF_STATUS);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ack must outlast the bus synchroniser delay
    sequence s_ack_hold;
        sda_oe [*8];
    endsequence
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (hresp == ISF_HRESP_OKAY) else $error("hresp not okay");
    a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata outside read");
    a_rdata_upper: assert property (rd_q |-> hrdata[31:8] == 24'h0) else $error("hrdata upper");
    a_status_spare: assert property (st_q |-> hrdata[7:4] == 4'h0 && !hrdata[0])
        else $error("status spare bits set");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i ##0 s_ack_hold)
        else $error("ack not held in clock low");
    a_oe_scl_high: assert property (scl_i && $past(scl_i, 3) |-> $stable(sda_oe))
        else $error("sda moved while clock high");
    a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_q) || $past(wr_q, 2)
        || $past(wr_q, 3)) else $error("irq fell without write");
endmodule : isf_checker
bind isf_status_flags isf_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_i), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

/* File: verification/isf_i2c_master.sv */
// behavioural i2c master on the far side of the bus pins
`timescale 1ns/1ns
`default_nettype none
module isf_i2c_master (
    // bus lines, sda open drain with pull-up
    output var logic scl,
    output var logic sda_drv,
    input wire logic sda_line
);
    localparam time HALF = 40;
    // clock starts high and still; start and bit calls leave it low, only stop leaves it high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start_cond;
        sda_drv = 1'b1;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda_drv = 1'b0;
        #HALF;
        scl = 1'b0;
        #HALF;
    endtask : start_cond
    task automatic stop_cond;
        sda_drv = 1'b0;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda_drv = 1'b1;
        #HALF;
    endtask : stop_cond
    task automatic one_bit(input logic b, output logic s);
        sda_drv = b;
        #(HALF / 2);
        scl = 1'b1;
        #HALF;
        s = sda_line;
        scl = 1'b0;
        #(HALF / 2);
    endtask : one_bit
    task automatic bits8(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) one_bit(d[i], s);
    endtask : bits8
    task automatic ack_bit(output logic a);
        one_bit(1'b1, a);
    endtask : ack_bit
endmodule : isf_i2c_master
`default_nettype wire

/* File: verification/testbench.sv */
// register level tests of the status flag block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import isf_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic arb_lost_pulse = 1'b0;
    logic smbus_mode = 1'b0;
    logic [2:0] timeout_pulse = 3'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic [1:0] hresp;
    wire logic sda_o;
    wire logic sda_oe;
    wire logic irq;
    wire logic scl;
    wire logic sda_drv;
    wire logic sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] rv;
    logic a;
    logic hit;
    logic [6:0] adr [5] = '{7'h10, 7'h13, 7'h17, 7'h00, 7'h14};
    // arb, timeouts, smbus, expected flag
    logic [5:0] ev [5] = '{6'h21, 6'h07, 6'h0A, 6'h12, 6'h04};
    // calling address and whether it should be answered
    logic [7:0] gc [4] = '{8'h01, 8'h19, 8'h45, 8'h24};
    always #2 hclk = ~hclk;
    isf_status_flags dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost_pulse(arb_lost_pulse),
        .smbus_mode(smbus_mode), .timeout_pulse(timeout_pulse), .irq(irq));
    isf_i2c_master m (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    // -----------------------------------------------------------------
    // bus and compare tasks
    // -----------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= ISF_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, ad};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        xfer(1'b1, ad, {24'h0, d});
    endtask : wr
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic rc(input string n, input logic [7:0] ad, input logic [31:0] mk,
        input logic [31:0] exp);
        xfer(1'b0, ad, 32'h0);
        chk(n, rv & mk, exp);
    endtask : rc
    task automatic pulse(input logic ar, input logic [2:0] to);
        @(posedge hclk);
        arb_lost_pulse <= ar;
        timeout_pulse <= to;
        @(posedge hclk);
        arb_lost_pulse <= 1'b0;
        timeout_pulse <= 3'h0;
    endtask : pulse
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // -----------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rc("status", ISF_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
        rc("filter", ISF_OFF_FILTER, 32'hFFFFFFFF, 32'h0);
        wr(8'h40, 8'hFF);
        rc("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
        // primary 0x10, range 0x14, span inclusive
        wr(ISF_OFF_PRIMARY, 8'h20);
        wr(ISF_OFF_RANGE, 8'h28);
        // general call, alert response and second address, range matching off
        wr(ISF_OFF_SECOND, 8'h44);
        wr(ISF_OFF_CTRL_TWO, 8'h83);
        for (int g = 0; g < 4; g++) begin
            wr(ISF_OFF_STATUS, 8'h02);
            m.start_cond();
            m.bits8({gc[g][7:1], 1'b0});
            m.ack_bit(a);
            chk("call ack", 32'(a), 32'(!gc[g][0]));
            rc("call flag", ISF_OFF_STATUS, 32'hA, {30'h0, gc[g][0], 1'b0});
            m.stop_cond();
        end
        wr(ISF_OFF_CTRL_TWO, 8'h08);
        for (int i = 0; i < 5; i++) begin
            wr(ISF_OFF_STATUS, 8'h02);
            m.start_cond();
            m.bits8({adr[i], i[0]});
            m.ack_bit(a);
            hit = adr[i] >= 7'h10 && adr[i] <= 7'h14;
            chk("addr ack", 32'(a), 32'(!hit));
            rc("range", ISF_OFF_STATUS, 32'h8, {28'h0, hit, 3'h0});
            rc("addr flag", ISF_OFF_STATUS, 32'h2, {30'h0, hit, 1'b0});
            if (hit) rc("dir", ISF_OFF_STATUS, 32'h4, {29'h0, i[0], 2'h0});
            if (i < 4) wr(ISF_OFF_CTRL_ONE, 8'h00);
            if (i < 4) m.stop_cond();
        end
        wr(ISF_OFF_CTRL_ONE, 8'h00);
        rc("range clr", ISF_OFF_STATUS, 32'h8, 32'h0);
        // data bytes in both ack modes, ack and nack
        for (int j = 0; j < 4; j++) begin
            wr(ISF_OFF_CTRL_TWO, {4'h0, 1'b1, j[1], 2'h0});
            wr(ISF_OFF_CTRL_ONE, {4'h0, j[0], 3'h0});
            wr(ISF_OFF_STATUS, 8'h02);
            m.bits8(8'hA5 ^ 8'(j));
            rc("early", ISF_OFF_STATUS, 32'h2, {30'h0, j[1], 1'b0});
            m.ack_bit(a);
            chk("data ack", 32'(a), 32'(j[0]));
            rc("late", ISF_OFF_STATUS, 32'h2, 32'h2);
        end
        m.stop_cond();
        // arbitration and timeouts, only arb unmasked
        wr(ISF_OFF_IRQ_MASK, 8'h04);
        for (int k = 0; k < 5; k++) begin
            smbus_mode <= ev[k][1];
            wr(ISF_OFF_IRQ_STATUS, 8'h3F);
            wr(ISF_OFF_STATUS, 8'h02);
            pulse(ev[k][5], ev[k][4:2]);
            rc("event", ISF_OFF_STATUS, 32'h2, {30'h0, ev[k][0], 1'b0});
            chk("irq", 32'(irq), 32'(ev[k][5]));
        end
        // stop/start interrupt and the clearing order
        wr(ISF_OFF_FILTER, 8'h70);
        wr(ISF_OFF_STATUS, 8'h02);
        m.start_cond();
        rc("start det", ISF_OFF_FILTER, 32'h10, 32'h10);
        rc("start flag", ISF_OFF_STATUS, 32'h2, 32'h2);
        wr(ISF_OFF_STATUS, 8'h02);
        rc("reassert", ISF_OFF_STATUS, 32'h2, 32'h2);
        wr(ISF_OFF_FILTER, 8'h30);
        wr(ISF_OFF_STATUS, 8'h02);
        rc("cleared", ISF_OFF_STATUS, 32'h2, 32'h0);
        m.stop_cond();
        rc("stop det", ISF_OFF_FILTER, 32'h40, 32'h40);
        rc("stop flag", ISF_OFF_STATUS, 32'h2, 32'h2);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
